// file: ugc_device.sv
`timescale 1ns/1ps
`include "ugc_cfg.svh"
// Summary of operation
// [RULE1] Writes locked after resume until key
// [RULE2] Unlock code B0, low key byte first
// [RULE3] Scratch written by B2, read by B3
// [RULE4] Scratch bit 15 zero, rest resets zero
// [RULE5] B4 returns last good SOF frame
// [RULE6] Frame number eleven bits, upper reserved
// [RULE7] Frame undefined after bus reset
// [RULE8] Byte bus: command high, low byte first
// [RULE9] Word bus: upper command byte ignored
// [RULE10] B5 returns identity and version
// [RULE11] Version byte is BCD encoded
// [RULE12] Host firmware checks identification value
// [RULE13] C0 returns four-byte interrupt sources
// [RULE14] Host reads all four bytes
// [RULE15] Endpoint flags bits 23 to 8
// [RULE16] Low byte bus event flags
// [RULE17] Enable register gates interrupt output
// [RULE18] Source read clears reset, resume, END_OF_TRANSFER_FLAG, SOF
// [RULE19] Endpoint flag cleared by status read
// [RULE20] Bus state mirrors live suspend level
// [RULE21] Reserved bits read zero
module ugc_device import ugc_pkg::*; #(
	parameter logic [7:0] CHIP_IDENTITY_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] SILICON_VERSION = 8'h10 // Arbitrary value, BCD
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	ugc_if.device BUS,
	input wire logic SOF_VALID,
	input wire logic [10:0] SOF_FRAME,
	input wire logic USB_BUS_RESET,
	input wire logic RESUME_EVENT,
	input wire logic SUSPEND_EVENT,
	input wire logic PSEUDO_SOF_FLAG_EVENT,
	input wire logic EOT_EVENT,
	input wire logic [15:0] EP_EVENT,
	input wire logic [15:0] EP_STATUS_READ,
	input wire logic BUS_SUSPENDED,
	input wire logic [31:0] INT_ENABLE,
	output logic WRITE_LOCKED,
	output logic INT_OUT
);
	typedef struct packed {
		ugc_dev_state_t state; // Command decode state
		logic byte_idx; // Data byte count within a word
		logic [1:0] int_idx; // Byte count within the source read
		logic [7:0] low_hold; // Low byte held on the byte bus
		logic locked; // Write protection active
		logic [15:0] scratch; // Scratch store
		logic [10:0] frame; // Last good frame number
		logic [15:0] word_sel; // Word being read out
		logic [31:0] int_src; // Interrupt source flags
		logic [31:0] int_snap; // Snapshot for the four-byte read
		logic [15:0] rdata; // Read data toward the host
		logic int_out; // Interrupt output
	} ugc_dev_st_t;
	ugc_dev_st_t st_reg;
	ugc_dev_st_t st_next;
	logic bus_susp_s; // Synchronised live bus state
	// Bus state is a pin level from the transceiver side
	ugc_sync2 #(.W(1)) ugc_sync2_inst (
		.clk(CORE_CLK),
		.rst(RESET),
		.d(BUS_SUSPENDED),
		.q(bus_susp_s)
	);
	// Byte of a 32-bit word by index
	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] i);
		pick_byte = w[8*i +: 8];
	endfunction
	logic cmd_wr; // Command byte written
	logic dat_wr; // Data write
	logic dat_rd; // Data read
	logic [31:0] int_view; // Readable source value
	assign cmd_wr = BUS.wr_strobe && BUS.command_data_select;
	assign dat_wr = BUS.wr_strobe && !BUS.command_data_select;
	assign dat_rd = BUS.rd_strobe && !BUS.command_data_select;
	// Live bus state overlays the stored flags; reserved bits forced low
	always_comb begin
		int_view = st_reg.int_src;
		int_view[`UGC_BUS_STATE_BIT] = bus_susp_s; // [RULE20]
		int_view[6] = 1'b0; // [RULE21]
		int_view[31:24] = 8'h00; // [RULE15] [RULE21]
	end
	// Next-state logic: decode, transfer and flag capture
	always_comb begin
		logic [31:0] clr; // Flags cleared this cycle
		logic [31:0] set; // Flags set this cycle
		logic [15:0] wr_word; // Completed written word
		logic wr_done; // A written word is complete
		clr = '0;
		set = '0;
		wr_word = 16'h0000;
		wr_done = 1'b0;
		st_next = st_reg;
		// Word assembly, low byte first on the byte bus
		if (dat_wr) begin
			if (BUS.wide_bus) begin
				wr_word = BUS.wdata;
				wr_done = 1'b1;
			end else if (!st_reg.byte_idx) begin
				st_next.low_hold = BUS.wdata[7:0]; // [RULE2] [RULE8]
				st_next.byte_idx = 1'b1;
			end else begin
				wr_word = {BUS.wdata[7:0], st_reg.low_hold};
				wr_done = 1'b1;
				st_next.byte_idx = 1'b0;
			end
		end
		// Read of one byte or word
		if (dat_rd) begin
			case (st_reg.state)
				UGC_RD_WORD: begin
					if (BUS.wide_bus) begin
						st_next.rdata = st_reg.word_sel; // [RULE9]
					end else begin
						st_next.rdata = {8'h00, pick_byte({16'h0000, st_reg.word_sel}, {1'b0, st_reg.byte_idx})}; // [RULE8]
						st_next.byte_idx = !st_reg.byte_idx;
					end
				end
				UGC_RD_INT: begin
					if (BUS.wide_bus) begin
						st_next.rdata = st_reg.int_idx[1] ? st_reg.int_snap[31:16] : st_reg.int_snap[15:0];
						st_next.int_idx = st_reg.int_idx + 2'd2;
					end else begin
						st_next.rdata = {8'h00, pick_byte(st_reg.int_snap, st_reg.int_idx)}; // [RULE13]
						st_next.int_idx = st_reg.int_idx + 2'd1;
					end
				end
				default: begin
					st_next.rdata = 16'h0000; // No read command active
				end
			endcase
		end
		// Command phase; only the low byte is decoded
		if (cmd_wr) begin
			st_next.byte_idx = 1'b0;
			st_next.int_idx = 2'd0;
			case (BUS.wdata[7:0]) // [RULE9]
				`UGC_CMD_UNLOCK: st_next.state = UGC_UNLOCK; // [RULE2]
				`UGC_CMD_SCR_WR: st_next.state = UGC_SCR_WR; // [RULE3]
				`UGC_CMD_SCR_RD: begin
					st_next.state = UGC_RD_WORD;
					st_next.word_sel = st_reg.scratch; // [RULE3]
				end
				`UGC_CMD_FRAME: begin
					st_next.state = UGC_RD_WORD;
					st_next.word_sel = {5'b00000, st_reg.frame}; // [RULE5] [RULE6]
				end
				`UGC_CMD_CHIPID: begin
					st_next.state = UGC_RD_WORD;
					st_next.word_sel = {CHIP_IDENTITY_CODE, SILICON_VERSION}; // [RULE10] [RULE11]
				end
				`UGC_CMD_INTSRC: begin
					st_next.state = UGC_RD_INT;
					st_next.int_snap = int_view; // [RULE13]
					clr[7:0] = `UGC_RD_CLR_MASK; // [RULE18]
				end
				default: st_next.state = UGC_IDLE; // Other codes belong elsewhere
			endcase
		end
		// Completed data words
		if (wr_done) begin
			case (st_reg.state)
				UGC_UNLOCK: begin
					if (wr_word == `UGC_UNLOCK_KEY) begin
						st_next.locked = 1'b0; // [RULE1]
					end
					st_next.state = UGC_IDLE;
				end
				UGC_SCR_WR: begin
					// Scratch writes obey the lock; the unlock key write is never blocked
					if (!st_reg.locked) begin
						st_next.scratch = wr_word & `UGC_SCR_MASK; // [RULE4] [RULE21]
					end
					st_next.state = UGC_IDLE;
				end
				default: st_next.state = st_reg.state;
			endcase
		end
		// Resume locks writes again
		if (RESUME_EVENT) begin
			st_next.locked = 1'b1; // [RULE1]
		end
		// Frame capture; after a bus reset the held value means nothing
		if (SOF_VALID) begin
			st_next.frame = SOF_FRAME; // [RULE5] [RULE7]
		end
		// Event flags; set beats clear in the same cycle
		set[`UGC_BUSRST_BIT] = USB_BUS_RESET; // [RULE16]
		set[`UGC_RESUME_BIT] = RESUME_EVENT;
		set[`UGC_SUSP_BIT] = SUSPEND_EVENT;
		set[`UGC_EOT_BIT] = EOT_EVENT;
		set[`UGC_SOF_BIT] = SOF_VALID;
		set[`UGC_PSEUDO_SOF_FLAG_BIT] = PSEUDO_SOF_FLAG_EVENT;
		set[`UGC_EP_LSB +: `UGC_EP_W] = EP_EVENT; // [RULE15]
		clr[`UGC_EP_LSB +: `UGC_EP_W] = EP_STATUS_READ; // [RULE19]
		st_next.int_src = ((st_reg.int_src & ~clr) | set) & 32'h00ffff3f; // [RULE21]
		// Any enabled source raises the output
		st_next.int_out = |(int_view & INT_ENABLE); // [RULE17]
	end
	// State register
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			st_reg <= '{state: UGC_IDLE, byte_idx: 1'b0, int_idx: 2'd0, low_hold: 8'h00,
				locked: 1'b0, scratch: `UGC_SCR_RST, frame: 11'h000, word_sel: 16'h0000,
				int_src: `UGC_INT_RST, int_snap: 32'h00000000, rdata: 16'h0000, int_out: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end
	assign BUS.rdata = st_reg.rdata;
	assign WRITE_LOCKED = st_reg.locked;
	assign INT_OUT = st_reg.int_out;
endmodule

// file: ugc_cfg.svh
`ifndef UGC_CFG_SVH
`define UGC_CFG_SVH
// Command codes
`define UGC_CMD_UNLOCK 8'hb0
`define UGC_CMD_SCR_WR 8'hb2
`define UGC_CMD_SCR_RD 8'hb3
`define UGC_CMD_FRAME 8'hb4
`define UGC_CMD_CHIPID 8'hb5
`define UGC_CMD_INTSRC 8'hc0
// Unlock key value
`define UGC_UNLOCK_KEY 16'haa37
// Field positions and widths
`define UGC_SCR_MASK 16'h7fff
`define UGC_FRAME_W 11
`define UGC_EP_LSB 8
`define UGC_EP_W 16
`define UGC_BUS_STATE_BIT 7
`define UGC_PSEUDO_SOF_FLAG_BIT 5
`define UGC_SOF_BIT 4
`define UGC_EOT_BIT 3
`define UGC_SUSP_BIT 2
`define UGC_RESUME_BIT 1
`define UGC_BUSRST_BIT 0
// Flags cleared by an interrupt source read: bus reset, resume, end of transfer, SOF
`define UGC_RD_CLR_MASK 8'h1b
// Reset values
`define UGC_SCR_RST 16'h0000
`define UGC_INT_RST 32'h00000000
`endif

// file: ugc_pkg.sv
package ugc_pkg;
	// Command decode states of the device end
	typedef enum logic [2:0] {
		UGC_IDLE,
		UGC_UNLOCK,
		UGC_SCR_WR,
		UGC_RD_WORD,
		UGC_RD_INT
	} ugc_dev_state_t;
	// Host end sequencer states
	typedef enum logic [2:0] {
		UGC_H_IDLE,
		UGC_H_CMD,
		UGC_H_DATA,
		UGC_H_DONE
	} ugc_host_state_t;
endpackage

// file: ugc_if.sv
`timescale 1ns/1ps
interface ugc_if;
	logic wr_strobe; // Host write strobe, one cycle
	logic rd_strobe; // Host read strobe, one cycle
	logic command_data_select; // 1 command phase, 0 data phase
	logic wide_bus; // 1 selects the 16-bit bus
	logic [15:0] wdata; // Host to device data
	logic [15:0] rdata; // Device to host data, valid cycle after rd_strobe
	modport device (input wr_strobe, rd_strobe, command_data_select, wide_bus, wdata, output rdata);
	modport host (output wr_strobe, rd_strobe, command_data_select, wide_bus, wdata, input rdata);
endinterface

// file: ugc_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for live pin levels
module ugc_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg; // First stage, read only by the second
	// Two stages; the first is never looked at by other logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// file: ugc_host.sv
`timescale 1ns/1ps
`include "ugc_cfg.svh"
// Host end: issues one command then its data transfers
module ugc_host import ugc_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic RESET,
	ugc_if.host BUS,
	input wire logic REQ,
	input wire logic [7:0] REQ_CMD,
	input wire logic REQ_WRITE,
	input wire logic [2:0] REQ_COUNT,
	input wire logic [15:0] REQ_WDATA,
	input wire logic REQ_WIDE,
	output logic BUSY,
	output logic DONE,
	output logic [31:0] RESULT
);
	typedef struct packed {
		ugc_host_state_t state; // Sequencer state
		logic [2:0] left; // Transfers left
		logic [1:0] idx; // Transfer index
		logic write; // Write transaction
		logic wide; // Word bus
		logic [15:0] wdata; // Word to send
		logic wr; // Write strobe
		logic rd; // Read strobe
		logic sel; // Command/data select
		logic [15:0] bus_wdata; // Data on bus
		logic capture; // Read data due this cycle
		logic [1:0] cap_idx; // Where it goes
		logic [1:0] got_idx; // Unit index of the data now standing on rdata
		logic busy;
		logic done;
		logic [31:0] result;
	} ugc_host_st_t;
	ugc_host_st_t st_reg;
	ugc_host_st_t st_next;
	// Sequencer: command, then data, low byte first
	always_comb begin
		st_next = st_reg;
		st_next.wr = 1'b0;
		st_next.rd = 1'b0;
		st_next.done = 1'b0;
		// The device registers rdata on the edge that takes the strobe,
		// so the data stands one cycle after the strobe has been seen
		st_next.capture = st_reg.rd;
		st_next.got_idx = st_reg.cap_idx;
		// Collect read data while it stands on the bus
		if (st_reg.capture) begin
			if (st_reg.wide) begin
				st_next.result[16*st_reg.got_idx[1] +: 16] = BUS.rdata;
			end else begin
				st_next.result[8*st_reg.got_idx +: 8] = BUS.rdata[7:0]; // [RULE8]
			end
		end
		case (st_reg.state)
			UGC_H_IDLE: begin
				if (REQ) begin
					st_next.state = UGC_H_CMD;
					st_next.left = REQ_COUNT; // Caller gives four bytes for C0 [RULE14]
					st_next.idx = 2'd0;
					st_next.write = REQ_WRITE;
					st_next.wide = REQ_WIDE;
					st_next.wdata = REQ_WDATA & `UGC_SCR_MASK | (REQ_CMD == `UGC_CMD_UNLOCK ? REQ_WDATA : 16'h0000); // [RULE4]
					st_next.result = 32'h00000000;
					st_next.busy = 1'b1;
					st_next.wr = 1'b1;
					st_next.sel = 1'b1; // [RULE8]
					st_next.bus_wdata = {8'h00, REQ_CMD};
				end
			end
			UGC_H_CMD, UGC_H_DATA: begin
				if (st_reg.left == 3'd0) begin
					st_next.state = UGC_H_DONE;
				end else begin
					st_next.state = UGC_H_DATA;
					st_next.sel = 1'b0;
					st_next.left = st_reg.left - 3'd1;
					st_next.idx = st_reg.idx + (st_reg.wide ? 2'd2 : 2'd1);
					if (st_reg.write) begin
						st_next.wr = 1'b1;
						st_next.bus_wdata = st_reg.wide ? st_reg.wdata :
							{8'h00, (st_reg.idx[0] ? st_reg.wdata[15:8] : st_reg.wdata[7:0])}; // [RULE2]
					end else begin
						st_next.rd = 1'b1;
						st_next.cap_idx = st_reg.idx;
					end
				end
			end
			UGC_H_DONE: begin
				// Wait out the last capture before reporting
				if (!st_reg.capture) begin
					st_next.state = UGC_H_IDLE;
					st_next.busy = 1'b0;
					st_next.done = 1'b1; // RESULT may carry identity for feature checks [RULE12]
				end
			end
			default: st_next.state = UGC_H_IDLE;
		endcase
	end
	// State register
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			st_reg <= '{state: UGC_H_IDLE, left: 3'd0, idx: 2'd0, write: 1'b0, wide: 1'b0,
				wdata: 16'h0000, wr: 1'b0, rd: 1'b0, sel: 1'b0, bus_wdata: 16'h0000,
				capture: 1'b0, cap_idx: 2'd0, got_idx: 2'd0, busy: 1'b0, done: 1'b0, result: 32'h00000000};
		end else begin
			st_reg <= st_next;
		end
	end
	assign BUS.wr_strobe = st_reg.wr;
	assign BUS.rd_strobe = st_reg.rd;
	assign BUS.command_data_select = st_reg.sel;
	assign BUS.wdata = st_reg.bus_wdata;
	assign BUS.wide_bus = st_reg.wide;
	assign BUSY = st_reg.busy;
	assign DONE = st_reg.done;
	assign RESULT = st_reg.result;
endmodule

// file: ugc_chk_asserts.sv
`timescale 1ns/1ps
`include "ugc_cfg.svh"
// Watches the command bus between the two ends
module ugc_chk (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic command_data_select,
	input wire logic wide_bus,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata
);
	logic [7:0] cmd_reg; // Last command code
	logic [2:0] idx_reg; // Data strobes since that command
	logic rd; // Read in the data phase
	assign rd = rd_strobe && !command_data_select;
	// A new command restarts the unit count
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			cmd_reg <= 8'h00;
			idx_reg <= 3'h0;
		end else if (wr_strobe && command_data_select) begin
			cmd_reg <= wdata[7:0];
			idx_reg <= 3'h0;
		end else if (rd_strobe || wr_strobe) begin
			idx_reg <= idx_reg + 3'h1;
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	AST_ONE_STROBE: assert property (!(wr_strobe && rd_strobe))
		else $error("Both strobes high");
	AST_RD_DATA_PHASE: assert property (rd_strobe |-> !command_data_select)
		else $error("Read in command phase");
	AST_SCR_TOP_W: assert property (rd && cmd_reg == `UGC_CMD_SCR_RD && wide_bus |=> !rdata[15])
		else $error("Scratch bit 15 set");
	AST_SCR_TOP_B: assert property (rd && cmd_reg == `UGC_CMD_SCR_RD && !wide_bus && idx_reg == 3'h1
		|=> !rdata[7])
		else $error("Scratch high bit set");
	AST_FRAME_W: assert property (rd && cmd_reg == `UGC_CMD_FRAME && wide_bus |=> rdata[15:11] == 5'h00)
		else $error("Frame reserved bits set");
	AST_FRAME_B: assert property (rd && cmd_reg == `UGC_CMD_FRAME && !wide_bus && idx_reg == 3'h1
		|=> rdata[7:3] == 5'h00)
		else $error("Frame high byte too wide");
	AST_ID_BCD: assert property (rd && cmd_reg == `UGC_CMD_CHIPID && !wide_bus && idx_reg == 3'h0
		|=> rdata[7:4] < 4'ha && rdata[3:0] < 4'ha)
		else $error("Version not BCD");
	AST_INT_RSV: assert property (rd && cmd_reg == `UGC_CMD_INTSRC && !wide_bus && idx_reg == 3'h3
		|=> rdata[7:0] == 8'h00)
		else $error("Source top byte set");
	AST_INT_BIT6: assert property (rd && cmd_reg == `UGC_CMD_INTSRC && !wide_bus && idx_reg == 3'h0
		|=> !rdata[6])
		else $error("Source bit 6 set");
endmodule

// file: usb_device_general_commands_tb.sv
`timescale 1ns/1ps
`include "ugc_cfg.svh"
module usb_device_general_commands_tb;
	localparam logic [7:0] ID_CODE = 8'h5a; // Arbitrary value
	localparam logic [7:0] VERSION = 8'h10; // Arbitrary value, BCD
	logic clk = 1'h0, rst = 1'h1, req = 1'h0, wr = 1'h0, wd = 1'h0;
	logic sofv = 1'h0, brst = 1'h0, resm = 1'h0, susp = 1'h0, pseudo_sof_flag = 1'h0, end_of_transfer_flag = 1'h0, slp = 1'h0;
	logic busy, done, locked, int_out;
	logic [7:0] cmd = 8'h00;
	logic [2:0] cnt = 3'h0;
	logic [10:0] frame = 11'h000;
	logic [15:0] wdat = 16'h0000, ep = 16'h0000, epr = 16'h0000;
	logic [31:0] inten = 32'h0, res;
	int error_cnt = 0, checks = 0, cyc = 0;
	ugc_if bus_if ();
	ugc_host ugc_host_inst (.CORE_CLK(clk), .RESET(rst), .BUS(bus_if.host), .REQ(req), .REQ_CMD(cmd),
		.REQ_WRITE(wr), .REQ_COUNT(cnt), .REQ_WDATA(wdat), .REQ_WIDE(wd), .BUSY(busy), .DONE(done), .RESULT(res));
	ugc_device #(.CHIP_IDENTITY_CODE(ID_CODE), .SILICON_VERSION(VERSION)) ugc_device_inst (.CORE_CLK(clk),
		.RESET(rst), .BUS(bus_if.device), .SOF_VALID(sofv), .SOF_FRAME(frame), .USB_BUS_RESET(brst),
		.RESUME_EVENT(resm), .SUSPEND_EVENT(susp), .PSEUDO_SOF_FLAG_EVENT(pseudo_sof_flag), .EOT_EVENT(end_of_transfer_flag), .EP_EVENT(ep),
		.EP_STATUS_READ(epr), .BUS_SUSPENDED(slp), .INT_ENABLE(inten), .WRITE_LOCKED(locked), .INT_OUT(int_out));
	ugc_chk ugc_chk_inst (.CORE_CLK(clk), .RESET(rst), .wr_strobe(bus_if.wr_strobe),
		.rd_strobe(bus_if.rd_strobe), .command_data_select(bus_if.command_data_select),
		.wide_bus(bus_if.wide_bus), .wdata(bus_if.wdata), .rdata(bus_if.rdata));
	// Free running core clock
	always #12.5 clk = ~clk;
	// Compare one result value
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Compare one flag output
	task automatic chk1(input string nm, input logic exp, input logic got);
		chk(nm, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One command and its data units, bounded wait on the done pulse
	task automatic xfer(input logic [7:0] c, input logic w, input logic [2:0] n, input logic [15:0] d,
		input logic wide);
		int i;
		@(negedge clk);
		cmd = c;
		wr = w;
		cnt = n;
		wdat = d;
		wd = wide;
		req = 1'h1;
		@(negedge clk);
		req = 1'h0;
		chk1("busy", 1'h1, busy);
		i = 0;
		while (done !== 1'h1 && i < 40) begin
			@(negedge clk);
			i++;
		end
		chk1("done", 1'h1, done);
		chk1("idle", 1'h0, busy);
	endtask
	// Event pulses last one cycle
	task automatic tick;
		@(negedge clk);
	endtask
	initial begin
		repeat (4) tick();
		rst = 1'h0;
		xfer(`UGC_CMD_SCR_RD, 1'h0, 3'h2, 16'h0, 1'h0); chk("scr rst", 32'h0, res);
		xfer(`UGC_CMD_INTSRC, 1'h0, 3'h4, 16'h0, 1'h0); chk("src rst", 32'h0, res);
		// A code this block does not own leaves no read path open
		xfer(8'hff, 1'h0, 3'h2, 16'h0, 1'h0); chk("no cmd", 32'h0, res);
		xfer(`UGC_CMD_SCR_WR, 1'h1, 3'h2, 16'h7abc, 1'h0);
		xfer(`UGC_CMD_SCR_RD, 1'h0, 3'h2, 16'h0, 1'h0); chk("scr byte", 32'h7abc, res);
		xfer(`UGC_CMD_SCR_WR, 1'h1, 3'h1, 16'hffff, 1'h1);
		xfer(`UGC_CMD_SCR_RD, 1'h0, 3'h1, 16'h0, 1'h1); chk("scr word", 32'h7fff, res);
		// Resume locks; wrong key and byte order keep the lock
		tick();
		resm = 1'h1;
		tick();
		resm = 1'h0;
		chk1("lock", 1'h1, locked);
		xfer(`UGC_CMD_SCR_WR, 1'h1, 3'h2, 16'h1234, 1'h0);
		xfer(`UGC_CMD_UNLOCK, 1'h1, 3'h2, 16'h37aa, 1'h0); chk1("bad key", 1'h1, locked);
		xfer(`UGC_CMD_SCR_RD, 1'h0, 3'h2, 16'h0, 1'h0); chk("scr lock", 32'h7fff, res);
		xfer(`UGC_CMD_UNLOCK, 1'h1, 3'h2, `UGC_UNLOCK_KEY, 1'h0); chk1("unlock", 1'h0, locked);
		frame = 11'h5a3;
		sofv = 1'h1;
		tick();
		sofv = 1'h0;
		xfer(`UGC_CMD_FRAME, 1'h0, 3'h1, 16'h0, 1'h0); chk("frm lo", 32'ha3, res);
		xfer(`UGC_CMD_FRAME, 1'h0, 3'h2, 16'h0, 1'h0); chk("frm 2b", 32'h5a3, res);
		xfer(`UGC_CMD_FRAME, 1'h0, 3'h1, 16'h0, 1'h1); chk("frm wd", 32'h5a3, res);
		xfer(`UGC_CMD_CHIPID, 1'h0, 3'h2, 16'h0, 1'h0); chk("id", {ID_CODE, VERSION}, res);
		// All bus events but SOF plus three endpoint flags at once, bus reset ahead of a new frame
		{brst, resm, susp, pseudo_sof_flag, end_of_transfer_flag, slp, ep} = {6'h3f, 16'h8003};
		tick();
		{brst, resm, susp, pseudo_sof_flag, end_of_transfer_flag, ep} = '0;
		frame = 11'h7ff;
		sofv = 1'h1;
		tick();
		sofv = 1'h0;
		repeat (3) tick();
		chk1("int off", 1'h0, int_out);
		xfer(`UGC_CMD_INTSRC, 1'h0, 3'h4, 16'h0, 1'h0); chk("src", 32'h8003bf, res);
		xfer(`UGC_CMD_INTSRC, 1'h0, 3'h2, 16'h0, 1'h1); chk("src clr", 32'h8003a4, res);
		epr = 16'h0001;
		slp = 1'h0;
		inten = 32'h200;
		tick();
		epr = 16'h0000;
		repeat (3) tick();
		chk1("int on", 1'h1, int_out);
		xfer(`UGC_CMD_INTSRC, 1'h0, 3'h4, 16'h0, 1'h0); chk("ep clr", 32'h800224, res);
		xfer(`UGC_CMD_FRAME, 1'h0, 3'h2, 16'h0, 1'h0); chk("frm new", 32'h7ff, res);
		report_and_stop();
	end
	// Hang guard, far beyond the roughly 150 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end
endmodule
